//--- dv/sqp_cpu_model.sv
// processor model issuing loads and stores to one socket
`timescale 1ns/1ps
`default_nettype none
module sqp_cpu_model (
  input  wire logic        clk_in,
  input  wire logic [31:0] rdata_in,
  input  wire logic        rvalid_in,
  output logic      [4:0]  addr_out,
  output logic             rd_out,
  output logic             wr_out,
  output logic      [31:0] wdata_out
);
  initial begin
    addr_out = 5'h1F;
    rd_out = 1'b0;
    wr_out = 1'b0;
    wdata_out = 32'h0000_0000;
  end
  task automatic ld(input logic [4:0] a, output logic [31:0] d);
    @(negedge clk_in);
    addr_out = a;
    rd_out = 1'b1;
    @(negedge clk_in);
    rd_out = 1'b0;
    // released lines show inverse, not a stale copy
    addr_out = ~addr_out;
    d = rvalid_in ? rdata_in : 32'hXXXX_XXXX;
  endtask
  task automatic st(input logic [4:0] a, input logic [31:0] w);
    @(negedge clk_in);
    addr_out = a;
    wdata_out = w;
    wr_out = 1'b1;
    @(negedge clk_in);
    wr_out = 1'b0;
    addr_out = ~addr_out;
    wdata_out = ~wdata_out;
  endtask
endmodule
`default_nettype wire

//--- dv/sqp_port_props.sv
// pin-level assertions for the socket register port
`timescale 1ns/1ps
`default_nettype none
module sqp_port_props
  import sqp_pkg::*;
(
  input wire logic                clk_sys_in,
  input wire logic                rstn_in,
  input wire logic [4:0]          bus_addr_in,
  input wire logic                bus_rd_in,
  input wire logic                bus_wr_in,
  input wire logic [31:0]         bus_wdata_in,
  input wire logic [31:0]         bus_rdata_out,
  input wire logic                bus_rvalid_out,
  input wire logic                ob_job_valid_out,
  input wire logic                ob_job_ready_in,
  input wire logic [DESC_W-1:0]   ob_job_desc_out,
  input wire logic [OB_LEN_W-1:0] ob_job_length_out,
  input wire logic [TYPE_W-1:0]   ob_job_type_out,
  input wire logic [OB_OP_W-1:0]  ob_job_opcode_out,
  input wire logic                plugin_enabled_out,
  input wire logic                plugin_online_out,
  input wire logic                plugin_marker_out
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rstn_in);
  wire       rd_spare = bus_rd_in && bus_addr_in == OFF_OB_SPARE;
  wire       rd_arr   = bus_rd_in && bus_addr_in == OFF_IB_ARRIVE;
  wire       rd_wo    = bus_rd_in && (bus_addr_in == OFF_OB_JOB || bus_addr_in == OFF_IB_JOB);
  wire       wr_mg    = bus_wr_in && bus_addr_in == OFF_PLUGIN;
  wire [1:0] cur      = {plugin_online_out, plugin_enabled_out};
  // online alone is never legal, nor a jump across two states
  wire       bad_mg   = bus_wdata_in[1:0] == ~cur || bus_wdata_in[1:0] == 2'b10;
  a_rvalid_one_after: assert property (bus_rvalid_out == $past(bus_rd_in))
    else $error("read answer not one cycle after load");
  a_spare_word_shape: assert property (rd_spare |=> bus_rdata_out[31:20] == 12'h000
    && bus_rdata_out[3:1] == 3'h0 && (!bus_rdata_out[0] || bus_rdata_out == EMPTY_WORD))
    else $error("spare read word malformed");
  a_arrival_empty_zero: assert property (rd_arr |=> bus_rdata_out[31:26] == 6'h00
    && bus_rdata_out[3:1] == 3'h0 && (!bus_rdata_out[0] || bus_rdata_out == EMPTY_WORD))
    else $error("arrival read word malformed");
  a_wo_reads_zero: assert property (rd_wo |=> bus_rdata_out == WORD_ZERO)
    else $error("write-only register read not zero");
  a_mgmt_read_back: assert property (bus_rd_in && bus_addr_in == OFF_PLUGIN
    |=> bus_rdata_out == {30'h0000_0000, $past(cur)})
    else $error("management read mismatch");
  a_no_online_alone: assert property (!(plugin_online_out && !plugin_enabled_out))
    else $error("online without enabled");
  a_bad_write_drop: assert property (wr_mg && bad_mg |=> $stable(cur))
    else $error("bad management write took effect");
  a_good_write_take: assert property (wr_mg && !bad_mg
    |=> cur == $past(bus_wdata_in[1:0]))
    else $error("legal management write lost");
  a_marker_on_leave: assert property (plugin_marker_out == $fell(plugin_online_out))
    else $error("marker pulse not tied to leaving online");
  a_op_zero_fields: assert property (ob_job_valid_out && ob_job_opcode_out == 2'h0
    |-> ob_job_length_out == 6'h00 && ob_job_type_out == 4'h0)
    else $error("opcode zero carries length or type");
  a_job_hold_stall: assert property (ob_job_valid_out && !ob_job_ready_in |=> ob_job_valid_out
    && $stable({ob_job_opcode_out, ob_job_type_out, ob_job_length_out, ob_job_desc_out}))
    else $error("outbound job changed while stalled");
  c_spare_pop: cover property (rd_spare ##1 !bus_rdata_out[0]);
  c_marker: cover property (plugin_marker_out);
  c_job_op0: cover property (ob_job_valid_out && ob_job_ready_in && ob_job_opcode_out == 2'h0);
endmodule
bind sqp_socket_port sqp_port_props u_props (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in),
  .bus_addr_in(bus_addr_in), .bus_rd_in(bus_rd_in), .bus_wr_in(bus_wr_in),
  .bus_wdata_in(bus_wdata_in), .bus_rdata_out(bus_rdata_out), .bus_rvalid_out(bus_rvalid_out),
  .ob_job_valid_out(ob_job_valid_out), .ob_job_ready_in(ob_job_ready_in),
  .ob_job_desc_out(ob_job_desc_out), .ob_job_length_out(ob_job_length_out),
  .ob_job_type_out(ob_job_type_out), .ob_job_opcode_out(ob_job_opcode_out),
  .plugin_enabled_out(plugin_enabled_out), .plugin_online_out(plugin_online_out),
  .plugin_marker_out(plugin_marker_out));
`default_nettype wire

//--- dv/testbench.sv
// self-checking bench for the socket register port
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) check_count++; if ((g) !== (e)) begin fails++; \
  $display("BAD %s exp %0h got %0h", n, e, g); end
module testbench;
  import sqp_pkg::*;
  logic clk_sys_in = 1'b0, rstn_in = 1'b0;
  logic [4:0] addr;
  logic rd, wr, rvalid, sv = 1'b0, sr, av = 1'b0, ae = 1'b0, ap = 1'b0, ar;
  logic [31:0] wdata, rdata, w, d, seed = 32'h0000_0044, rs = 32'h0000_0044;
  logic [19:0] sd = 20'h00000, ad = 20'h00000, od, id;
  logic [3:0] at = 4'h0, ot, irq;
  logic [5:0] ol;
  logic [1:0] oo, st_cur;
  logic [2:0] io;
  logic ojv, ojr = 1'b0, ijv, ijr = 1'b0, ik, pen, pon, prs, pmk, stall = 1'b1;
  logic [31:0] sq[$], aq[$], oq[$], iq[$], oe, ie;
  int fails = 0, check_count = 0, cyc = 0, marks = 0, i;
  always #12.5 clk_sys_in = ~clk_sys_in;
  sqp_cpu_model cpu (.clk_in(clk_sys_in), .rdata_in(rdata), .rvalid_in(rvalid),
    .addr_out(addr), .rd_out(rd), .wr_out(wr), .wdata_out(wdata));
  sqp_socket_port dut (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .bus_addr_in(addr),
    .bus_rd_in(rd), .bus_wr_in(wr), .bus_wdata_in(wdata), .bus_rdata_out(rdata),
    .bus_rvalid_out(rvalid), .spare_valid_in(sv), .spare_desc_in(sd), .spare_ready_out(sr),
    .ob_job_valid_out(ojv), .ob_job_ready_in(ojr), .ob_job_desc_out(od),
    .ob_job_length_out(ol), .ob_job_type_out(ot), .ob_job_opcode_out(oo),
    .arr_valid_in(av), .arr_desc_in(ad), .arr_type_in(at), .arr_error_in(ae),
    .arr_payload_in(ap), .arr_ready_out(ar), .ib_job_valid_out(ijv), .ib_job_ready_in(ijr),
    .ib_job_desc_out(id), .ib_job_opcode_out(io), .ib_job_keep_out(ik),
    .plugin_enabled_out(pen), .plugin_online_out(pon), .plugin_reset_out(prs),
    .plugin_marker_out(pmk), .irq_src_out(irq));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    return s ^ (s << 5);
  endfunction
  function automatic logic [31:0] ob_exp(input logic [31:0] v);
    return v[31:30] == 2'h0 ? {12'h000, v[19:0]} : v;
  endfunction
  function automatic logic [1:0] mg_next(input logic [1:0] c, input logic [1:0] v);
    return (v == ~c || v == 2'b10) ? c : v;
  endfunction
  task automatic print_verdict;
    if (fails == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic feed(input bit arr, input logic [31:0] v);
    @(negedge clk_sys_in);
    if (arr) {ap, ae, at, ad} = v[25:0];
    else sd = v[19:0];
    av = arr;
    sv = !arr;
    @(negedge clk_sys_in);
    `CHK("fill_ready", 1'b1, arr ? ar : sr)
    av = 1'b0;
    sv = 1'b0;
    {ap, ae, at, ad, sd} = ~{ap, ae, at, ad, sd};
  endtask
  always @(negedge clk_sys_in) begin
    rs = xs(rs);
    {ojr, ijr} = stall ? 2'b00 : rs[1:0];
  end
  always @(posedge clk_sys_in) begin
    cyc++;
    if (pmk === 1'b1) marks++;
    if (ojv && ojr) begin
      oe = oq.size() ? ob_exp(oq.pop_front()) : 32'hXXXX_XXXX;
      `CHK("ob_job", oe, {oo, ot, ol, od})
    end
    // inbound opcode, keep flag and descriptor
    if (ijv && ijr) begin
      ie = iq.size() ? iq.pop_front() : 32'hXXXX_XXXX;
      `CHK("ib_job", {ie[31:28], ie[19:0]}, {io, ik, id})
    end
    if (cyc == 5000) begin fails++; print_verdict(); end
  end
  initial begin
    repeat (5) @(posedge clk_sys_in);
    @(negedge clk_sys_in) rstn_in = 1'b1;
    `CHK("irq_reset", 4'b0001, irq)
    cpu.ld(OFF_OB_SPARE, d); `CHK("spare_empty", EMPTY_WORD, d)
    cpu.ld(OFF_IB_ARRIVE, d); `CHK("arr_empty", EMPTY_WORD, d)
    cpu.ld(OFF_IB_JOB, d); `CHK("wo_read", WORD_ZERO, d)
    cpu.ld(5'h14, d); `CHK("unmapped", WORD_ZERO, d)
    for (i = 0; i < 10; i++) begin
      seed = xs(seed);
      if (i < 4) sq.push_back(seed); else aq.push_back(seed);
      feed(i >= 4, seed);
    end
    @(negedge clk_sys_in);
    `CHK("irq_fill", 4'b0100, irq)
    for (i = 0; i < 4; i++) begin cpu.ld(OFF_OB_SPARE, d); `CHK("spare", {12'h000, sq[i][19:4], 4'h0}, d) end
    for (i = 0; i < 6; i++) begin cpu.ld(OFF_IB_ARRIVE, d); `CHK("arrival", {6'h00, aq[i][25:4], 4'h0}, d) end
    @(negedge clk_sys_in);
    `CHK("irq_drain", 4'b0001, irq)
    for (i = 0; i < 20; i++) begin
      // aligned descriptors; length any of the 6-bit range
      seed = xs(seed);
      w = {i[1:0], seed[29:4], 4'h0};
      if (!irq[IRQ_OBJOB_FULL]) begin oq.push_back(w); cpu.st(OFF_OB_JOB, w); end
      w = {i[2:0], seed[28:27], seed[26:4] ^ 23'h5A5A5A, 4'h0};
      if (!irq[IRQ_IBJOB_FULL]) begin iq.push_back(w); cpu.st(OFF_IB_JOB, w); end
      @(negedge clk_sys_in);
    end
    `CHK("irq_full", 4'b1010, irq & 4'b1010)
    cpu.st(OFF_OB_JOB, 32'hC000_0010);
    cpu.st(OFF_IB_JOB, 32'hE000_0010);
    stall = 1'b0;
    for (i = 0; i < 300 && (oq.size() || iq.size()); i++) @(negedge clk_sys_in);
    repeat (10) @(negedge clk_sys_in);
    `CHK("jobs_left", 0, oq.size() + iq.size())
    st_cur = 2'b00;
    for (i = 0; i < 32; i++) begin
      w = {30'h0000_0000, 2'((8'hE7 >> (i % 8)) & 8'h03) ^ i[1:0]};
      cpu.st(OFF_PLUGIN, w);
      st_cur = mg_next(st_cur, w[1:0]);
      cpu.ld(OFF_PLUGIN, d); `CHK("mgmt", {30'h0000_0000, st_cur}, d)
    end
    `CHK("plugin_reset", ~st_cur[0], prs)
    `CHK("markers", 1'b1, marks > 0)
    print_verdict();
  end
endmodule
`default_nettype wire

//--- hw/sqp_pkg.sv
// shared constants, field layouts and types of the socket queue register port
package sqp_pkg;

  // register byte offsets within one socket
  localparam logic [4:0] OFF_OB_SPARE  = 5'h00;
  localparam logic [4:0] OFF_OB_JOB    = 5'h04;
  localparam logic [4:0] OFF_IB_ARRIVE = 5'h08;
  localparam logic [4:0] OFF_IB_JOB    = 5'h0C;
  localparam logic [4:0] OFF_PLUGIN    = 5'h1C;

  // queue geometry
  localparam int          QUEUE_DEPTH   = 16;
  localparam int          PTR_W         = 4;
  localparam int          CNT_W         = 5;
  localparam logic [4:0]  SPARE_LOW_MARK = 5'h02;

  // descriptor field, byte offset into on-chip memory, low nibble always zero
  localparam int DESC_LSB   = 0;
  localparam int DESC_MSB   = 19;
  localparam int DESC_W     = 20;
  localparam int ALIGN_BITS = 4;
  localparam int EMPTY_BIT  = 0;

  // outbound instruction
  localparam int OB_LEN_LSB  = 20;
  localparam int OB_LEN_W    = 6;
  localparam int OB_TYPE_LSB = 26;
  localparam int OB_OP_LSB   = 30;
  localparam int OB_OP_W     = 2;

  // inbound arrival entry
  localparam int ARR_TYPE_LSB = 20;
  localparam int ARR_ERR_BIT  = 24;
  localparam int ARR_PAY_BIT  = 25;

  // inbound instruction
  localparam int IB_KEEP_BIT = 28;
  localparam int IB_OP_LSB   = 29;
  localparam int IB_OP_W     = 3;

  localparam int TYPE_W = 4;

  // plugin management flags
  localparam int ENABLED_BIT = 0;
  localparam int ONLINE_BIT  = 1;

  localparam logic [31:0] WORD_ZERO  = 32'h0000_0000;
  localparam logic [31:0] EMPTY_WORD = 32'h0000_0001;

  // interrupt source numbers
  localparam int IRQ_SPARE_LOW  = 0;
  localparam int IRQ_OBJOB_FULL = 1;
  localparam int IRQ_ARR_READY  = 2;
  localparam int IRQ_IBJOB_FULL = 3;

  typedef enum logic [2:0] {
    SQP_DISABLED = 3'b001,
    SQP_OFFLINE  = 3'b010,
    SQP_ONLINE   = 3'b100
  } sqp_state_t;

endpackage

//--- hw/sqp_plugin_mgr.sv
// plugin state keeper: disabled, offline, online with guarded transitions
`timescale 1ns/1ps
`default_nettype none
module sqp_plugin_mgr
  import sqp_pkg::*;
(
  input  wire logic       clk_sys_in,
  input  wire logic       rstn_in,
  input  wire logic       wr_in,
  input  wire logic [1:0] flags_in,
  output logic            enabled_out,
  output logic            online_out,
  output logic            marker_out
);

  sqp_state_t state;
  sqp_state_t next_state;

  wire req_en = flags_in[ENABLED_BIT];
  wire req_on = flags_in[ONLINE_BIT];

  // [R19] drop bad writes
  always_comb begin
    next_state = state;
    if (wr_in) begin
      case (state)
        SQP_DISABLED: begin
          if (req_en && !req_on) begin
            next_state = SQP_OFFLINE;
          end
        end
        SQP_OFFLINE: begin
          if (!req_en && !req_on) begin
            next_state = SQP_DISABLED;
          end else if (req_en && req_on) begin
            next_state = SQP_ONLINE;
          end
        end
        SQP_ONLINE: begin
          if (req_en && !req_on) begin
            next_state = SQP_OFFLINE;
          end
        end
        default: begin
          next_state = SQP_DISABLED;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state       <= SQP_DISABLED;
      enabled_out <= 1'b0;
      online_out  <= 1'b0;
      marker_out  <= 1'b0;
    end else begin
      state       <= next_state;
      // [R18] flag encoding
      enabled_out <= (next_state != SQP_DISABLED);
      online_out  <= (next_state == SQP_ONLINE);
      // [R20] marker on going from online to offline
      marker_out  <= (state == SQP_ONLINE) && (next_state == SQP_OFFLINE);
    end
  end

endmodule
`default_nettype wire

//--- hw/sqp_queue.sv
// one 32-bit word queue with registered room, avail and count
`timescale 1ns/1ps
`default_nettype none
module sqp_queue
  import sqp_pkg::*;
(
  input  wire logic   clk_sys_in,
  input  wire logic   rstn_in,
  sqp_queue_if.store  q
);

  logic [31:0]      mem [QUEUE_DEPTH];
  logic [PTR_W-1:0] wr_ptr;
  logic [PTR_W-1:0] rd_ptr;
  logic [CNT_W-1:0] count;
  logic             room;
  logic             avail;

  wire              do_push    = q.push && room;
  wire              do_pop     = q.pop && avail;
  wire [CNT_W-1:0]  next_count = CNT_W'(count + {4'h0, do_push} - {4'h0, do_pop});

  assign q.head  = mem[rd_ptr];
  assign q.room  = room;
  assign q.avail = avail;
  assign q.count = count;

  // storage holds no reset; pointers, count, room and avail do
  always_ff @(posedge clk_sys_in) begin
    if (do_push) begin
      mem[wr_ptr] <= q.push_data;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
      room   <= 1'b1;
      avail  <= 1'b0;
    end else begin
      wr_ptr <= PTR_W'(wr_ptr + {3'h0, do_push});
      rd_ptr <= PTR_W'(rd_ptr + {3'h0, do_pop});
      count  <= next_count;
      room   <= (next_count != CNT_W'(QUEUE_DEPTH));
      avail  <= (next_count != '0);
    end
  end

endmodule
`default_nettype wire

//--- hw/sqp_queue_if.sv
// signals between a queue store and the logic that fills and drains it
`timescale 1ns/1ps
`default_nettype none
interface sqp_queue_if;
  logic        push;
  logic [31:0] push_data;
  logic        pop;
  logic [31:0] head;
  logic        room;
  logic        avail;
  logic [4:0]  count;

  modport store (
    input  push,
    input  push_data,
    input  pop,
    output head,
    output room,
    output avail,
    output count
  );

  modport user (
    output push,
    output push_data,
    output pop,
    input  head,
    input  room,
    input  avail,
    input  count
  );
endinterface
`default_nettype wire

//--- hw/sqp_socket_port.sv
// socket register port: four descriptor queues and plugin management
// Notes on behaviour
// [R1] spare read with entries pops one, returns it with bit 0 clear
// [R2] spare read when empty returns 1 only and pops nothing
// [R3] returned descriptor references are byte offsets, low four bits zero
// [R4] store to outbound job register pushes the word; register reads zero
// [R5] software supplies aligned, well-formed outbound descriptors
// [R6] software keeps header length in quadwords within plugin maximum
// [R7] opcode zero: length and frame type are ignored
// [R8] outbound frame type 0..15 forwarded to plugin
// [R9] outbound opcode 0..3 forwarded to outbound engine
// [R10] arrival read with entries pops one, returns it with bit 0 clear
// [R11] arrival read when empty returns 1 with all fields zero
// [R12] arrival entry carries header error flag, independent of payload
// [R13] arrival entry carries payload flag
// [R14] arrival entry carries plugin frame type 0..15
// [R15] store to inbound job register queues instruction, opcode 0..7
// [R16] inbound keep flag withholds descriptor from recycling
// [R17] management register read and write; upper bits reserved, read zero
// [R18] flags: 00 disabled, 01 offline, 11 online; online alone forbidden
// [R19] writes reaching bad state or transition dropped silently
// [R20] leaving online makes plugin emit inbound marker frame
// [R21] four interrupt levels: spare low, job full, arrival ready, job full
// [R22] field positions above alignment bits fixed in shared layout
`timescale 1ns/1ps
`default_nettype none
module sqp_socket_port
  import sqp_pkg::*;
(
  input  wire logic              clk_sys_in,
  input  wire logic              rstn_in,
  // processor load and store port
  input  wire logic [4:0]        bus_addr_in,
  input  wire logic              bus_rd_in,
  input  wire logic              bus_wr_in,
  input  wire logic [31:0]       bus_wdata_in,
  output logic      [31:0]       bus_rdata_out,
  output logic                   bus_rvalid_out,
  // spare descriptors from the outbound engine
  input  wire logic              spare_valid_in,
  input  wire logic [DESC_W-1:0] spare_desc_in,
  output logic                   spare_ready_out,
  // outbound instructions to the outbound engine
  output logic                   ob_job_valid_out,
  input  wire logic              ob_job_ready_in,
  output logic [DESC_W-1:0]      ob_job_desc_out,
  output logic [OB_LEN_W-1:0]    ob_job_length_out,
  output logic [TYPE_W-1:0]      ob_job_type_out,
  output logic [OB_OP_W-1:0]     ob_job_opcode_out,
  // received frames from the inbound engine
  input  wire logic              arr_valid_in,
  input  wire logic [DESC_W-1:0] arr_desc_in,
  input  wire logic [TYPE_W-1:0] arr_type_in,
  input  wire logic              arr_error_in,
  input  wire logic              arr_payload_in,
  output logic                   arr_ready_out,
  // inbound instructions to the inbound engine
  output logic                   ib_job_valid_out,
  input  wire logic              ib_job_ready_in,
  output logic [DESC_W-1:0]      ib_job_desc_out,
  output logic [IB_OP_W-1:0]     ib_job_opcode_out,
  output logic                   ib_job_keep_out,
  // plugin control
  output logic                   plugin_enabled_out,
  output logic                   plugin_online_out,
  output logic                   plugin_reset_out,
  output logic                   plugin_marker_out,
  // interrupt sources
  output logic [3:0]             irq_src_out
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // forces the alignment nibble of a descriptor reference to zero
  function automatic logic [DESC_W-1:0] align_desc(input logic [DESC_W-1:0] d);
    align_desc = {d[DESC_W-1:ALIGN_BITS], {ALIGN_BITS{1'b0}}};
  endfunction

  function automatic logic hit(input logic [4:0] a, input logic [4:0] off);
    hit = (a == off);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // queues

  sqp_queue_if q_spare ();
  sqp_queue_if q_objob ();
  sqp_queue_if q_arr ();
  sqp_queue_if q_ibjob ();

  sqp_queue u_spare (
    .clk_sys_in (clk_sys_in),
    .rstn_in    (rstn_in),
    .q          (q_spare)
  );

  sqp_queue u_objob (
    .clk_sys_in (clk_sys_in),
    .rstn_in    (rstn_in),
    .q          (q_objob)
  );

  sqp_queue u_arr (
    .clk_sys_in (clk_sys_in),
    .rstn_in    (rstn_in),
    .q          (q_arr)
  );

  sqp_queue u_ibjob (
    .clk_sys_in (clk_sys_in),
    .rstn_in    (rstn_in),
    .q          (q_ibjob)
  );

  ////////////////////////////////////////////////////////////////////////////
  // address decode

  wire rd_spare  = bus_rd_in && hit(bus_addr_in, OFF_OB_SPARE);
  wire rd_arr    = bus_rd_in && hit(bus_addr_in, OFF_IB_ARRIVE);
  wire rd_plugin = bus_rd_in && hit(bus_addr_in, OFF_PLUGIN);
  wire wr_objob  = bus_wr_in && hit(bus_addr_in, OFF_OB_JOB);
  wire wr_ibjob  = bus_wr_in && hit(bus_addr_in, OFF_IB_JOB);
  wire wr_plugin = bus_wr_in && hit(bus_addr_in, OFF_PLUGIN);

  ////////////////////////////////////////////////////////////////////////////
  // fill sides driven by the engines and by processor job stores

  // [R3] aligned spare references
  assign q_spare.push      = spare_valid_in;
  assign q_spare.push_data = {12'h000, align_desc(spare_desc_in)};
  assign spare_ready_out   = q_spare.room;

  // [R12] error, [R13] payload and [R14] type packed per entry
  assign q_arr.push      = arr_valid_in;
  assign q_arr.push_data = {6'h00, arr_payload_in, arr_error_in, arr_type_in,
                            align_desc(arr_desc_in)};
  assign arr_ready_out   = q_arr.room;

  // [R4] outbound job store pushes word, full queue drops it
  assign q_objob.push      = wr_objob;
  assign q_objob.push_data = bus_wdata_in;

  // [R15] inbound job store queued
  assign q_ibjob.push      = wr_ibjob;
  assign q_ibjob.push_data = bus_wdata_in;

  ////////////////////////////////////////////////////////////////////////////
  // drain sides read by the processor

  // [R1] pop only when an entry is present
  assign q_spare.pop = rd_spare;
  // [R10] pop one arrival per read
  assign q_arr.pop   = rd_arr;

  logic [31:0] next_rdata;

  always_comb begin
    next_rdata = WORD_ZERO;
    if (rd_spare) begin
      // [R2] empty marker with zero descriptor
      next_rdata = q_spare.avail ? q_spare.head : EMPTY_WORD;
    end else if (rd_arr) begin
      // [R11] empty marker, all fields zero
      next_rdata = q_arr.avail ? q_arr.head : EMPTY_WORD;
    end else if (rd_plugin) begin
      // [R17] reserved bits read zero
      next_rdata = {30'h0000_0000, plugin_online_out, plugin_enabled_out};
    end
  end

  // write-only and unmapped offsets answer zero
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      bus_rdata_out  <= WORD_ZERO;
      bus_rvalid_out <= 1'b0;
    end else begin
      bus_rdata_out  <= next_rdata;
      bus_rvalid_out <= bus_rd_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outbound job output stage

  wire         ob_load = (!ob_job_valid_out || ob_job_ready_in) && q_objob.avail;
  // [R22] fixed field layout
  wire  [31:0] ob_word = q_objob.head;
  wire  [OB_OP_W-1:0] ob_op = ob_word[OB_OP_LSB +: OB_OP_W];
  // [R7] opcode zero masks length and type
  wire         ob_keep_fields = (ob_op != '0);

  assign q_objob.pop = ob_load;

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ob_job_valid_out  <= 1'b0;
      ob_job_desc_out   <= '0;
      ob_job_length_out <= '0;
      ob_job_type_out   <= '0;
      ob_job_opcode_out <= '0;
    end else if (!ob_job_valid_out || ob_job_ready_in) begin
      ob_job_valid_out  <= q_objob.avail;
      if (q_objob.avail) begin
        ob_job_desc_out   <= ob_word[DESC_MSB:DESC_LSB];
        ob_job_length_out <= ob_keep_fields ? ob_word[OB_LEN_LSB +: OB_LEN_W] : '0;
        // [R8] frame type forwarded
        ob_job_type_out   <= ob_keep_fields ? ob_word[OB_TYPE_LSB +: TYPE_W] : '0;
        // [R9] opcode forwarded
        ob_job_opcode_out <= ob_op;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // inbound job output stage

  wire        ib_load = (!ib_job_valid_out || ib_job_ready_in) && q_ibjob.avail;
  wire [31:0] ib_word = q_ibjob.head;

  assign q_ibjob.pop = ib_load;

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ib_job_valid_out  <= 1'b0;
      ib_job_desc_out   <= '0;
      ib_job_opcode_out <= '0;
      ib_job_keep_out   <= 1'b0;
    end else if (!ib_job_valid_out || ib_job_ready_in) begin
      ib_job_valid_out <= q_ibjob.avail;
      if (q_ibjob.avail) begin
        ib_job_desc_out   <= ib_word[DESC_MSB:DESC_LSB];
        // [R15] opcode to inbound engine
        ib_job_opcode_out <= ib_word[IB_OP_LSB +: IB_OP_W];
        // [R16] keep flag forwarded
        ib_job_keep_out   <= ib_word[IB_KEEP_BIT];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // plugin management

  logic mgr_enabled;
  logic mgr_online;
  logic mgr_marker;

  // [R17] management write, reserved bits ignored
  sqp_plugin_mgr u_mgr (
    .clk_sys_in  (clk_sys_in),
    .rstn_in     (rstn_in),
    .wr_in       (wr_plugin),
    .flags_in    (bus_wdata_in[1:0]),
    .enabled_out (mgr_enabled),
    .online_out  (mgr_online),
    .marker_out  (mgr_marker)
  );

  assign plugin_enabled_out = mgr_enabled;
  assign plugin_online_out  = mgr_online;
  assign plugin_marker_out  = mgr_marker;

  // reset is held one cycle later than the flag, harmless for a level
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      plugin_reset_out <= 1'b1;
    end else begin
      plugin_reset_out <= !mgr_enabled;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt sources, levels registered one cycle behind the queue flags

  // [R21] four source levels
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      irq_src_out <= 4'h1;
    end else begin
      irq_src_out[IRQ_SPARE_LOW]  <= (q_spare.count <= SPARE_LOW_MARK);
      irq_src_out[IRQ_OBJOB_FULL] <= !q_objob.room;
      irq_src_out[IRQ_ARR_READY]  <= q_arr.avail;
      irq_src_out[IRQ_IBJOB_FULL] <= !q_ibjob.room;
    end
  end

endmodule
`default_nettype wire
